// ### src/breaker_failure_timing_logic.sv
// breaker failure timing, decision logic and axi4-lite register file
`timescale 1ns/1ps
// What this block does
// - condition is one of normal, start, retrip, failure on, blocked
// - behaviour reported as on, blocked, test, test/blocked or off
// - block input sampled once at each program cycle start, held all cycle
// - pick-up without block asserts start; timers run once the criterion is met
// - pick-up with block gives blocked indication and no timers
// - block arriving during start drops start like loss of pick-up
// - retrip and failure timers share one pick-up condition
// - retrip enable, default yes; disabled means retrip never asserts
// - retrip after condition persists retrip delay, 5 ms steps, 100 ms
// - failure output after condition persists failure delay, default 200 ms
// - current-only: current above threshold starts timers, trip ignored
// - current-only: timers reset when currents drop below 97 % of thresholds
// - current-and-output: current alone halts timers until trip active
// - current-and-output: retrip then failure on expiry with condition held
// - current-and-output: reset when current falls or trip resets
// - current-or-output: timers run on current or trip active
// - current-or-output: reset only when current low and trip reset
// - release at 97 % of threshold; any phase over threshold picks up
// - criterion chooses current, trip contact or their combinations
module breaker_failure_timing_logic #(
  parameter int CYCLE_CLKS = bf_timing_pkg::CYCLE_CLKS,
  parameter int CW = 32
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // measured magnitudes, same clock domain
  input wire logic [31:0] phase_mag [3],
  input wire logic [31:0] residual_mag,
  // external pins
  input wire logic block_pin,
  input wire logic primary_trip_pin,
  // outputs
  output logic start_out,
  output logic retrip_out,
  output logic breaker_failure_trip,
  output logic blocked_out,
  output logic [2:0] function_condition,
  output logic [2:0] logical_node_behaviour,
  // axi4-lite slave
  input wire logic [7:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [7:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready
);
  // ------------------------------------------------------------
  // pin synchronisers and program cycle tick
  // ------------------------------------------------------------
  logic [1:0] blk_sync_reg, trp_sync_reg;
  logic [31:0] tick_cnt_reg, tick_cnt_next;
  logic tick;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      blk_sync_reg <= 2'h0;
      trp_sync_reg <= 2'h0;
    end else begin
      blk_sync_reg <= {blk_sync_reg[0], block_pin};
      trp_sync_reg <= {trp_sync_reg[0], primary_trip_pin};
    end
  end
  assign tick = (tick_cnt_reg == 32'(CYCLE_CLKS - 1));
  always_comb begin
    tick_cnt_next = tick ? 32'h0 : tick_cnt_reg + 32'h1;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) tick_cnt_reg <= 32'h0;
    else tick_cnt_reg <= tick_cnt_next;
  end
  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic [31:0] ctrl_reg, ph_thr_reg, res_thr_reg, retr_dly_reg, bf_dly_reg;
  logic [31:0] cycle_cnt_reg;
  bf_timing_pkg::criterion_t crit;
  bf_timing_pkg::behaviour_t beh;
  logic retr_en, res_en;
  assign crit = bf_timing_pkg::criterion_t'(
    ctrl_reg[bf_timing_pkg::CTRL_CRIT_LSB +: 2]);
  assign retr_en = ctrl_reg[bf_timing_pkg::CTRL_RETR_EN];
  assign res_en = ctrl_reg[bf_timing_pkg::CTRL_RES_EN];
  always_comb begin
    unique case (ctrl_reg[bf_timing_pkg::CTRL_MODE_LSB +: 3])
      3'h1: beh = bf_timing_pkg::BEH_BLOCKED;
      3'h2: beh = bf_timing_pkg::BEH_TEST;
      3'h3: beh = bf_timing_pkg::BEH_TEST_BLOCKED;
      3'h4: beh = bf_timing_pkg::BEH_OFF;
      default: beh = bf_timing_pkg::BEH_ON;
    endcase
  end
  // ------------------------------------------------------------
  // pick-up with 97 % release, per phase and for the residual
  // ------------------------------------------------------------
  logic [3:0] pk_reg, pk_next;
  logic [31:0] thr [4];
  logic [31:0] mag [4];
  assign thr[0] = ph_thr_reg;
  assign thr[1] = ph_thr_reg;
  assign thr[2] = ph_thr_reg;
  assign thr[3] = res_thr_reg;
  assign mag[0] = phase_mag[0];
  assign mag[1] = phase_mag[1];
  assign mag[2] = phase_mag[2];
  assign mag[3] = res_en ? residual_mag : 32'h0;
  for (genvar g = 0; g < 4; g++) begin : g_pk
    logic [39:0] m100, t97;
    assign m100 = 40'(mag[g]) * 40'd100;
    assign t97 = 40'(thr[g]) * 40'(bf_timing_pkg::PCT_RELEASE);
    always_comb begin
      // any single phase picks up; release below 97 % only
      if (mag[g] > thr[g]) pk_next[g] = 1'b1;
      else if (m100 < t97) pk_next[g] = 1'b0;
      else pk_next[g] = pk_reg[g];
    end
  end
  // ------------------------------------------------------------
  // decision and timers, stepped once per program cycle
  // ------------------------------------------------------------
  logic blk_reg, blk_next, cur_pk, trip_act, pickup, run;
  logic [31:0] tmr_reg, tmr_next;
  logic start_reg, start_next, rt_reg, rt_next, bf_reg, bf_next;
  logic bk_reg, bk_next;
  assign cur_pk = |pk_reg;
  assign trip_act = trp_sync_reg[1];
  always_comb begin
    unique case (crit)
      bf_timing_pkg::CRIT_CURRENT: run = cur_pk;
      bf_timing_pkg::CRIT_AND_DO: run = cur_pk & trip_act;
      bf_timing_pkg::CRIT_OR_DO: run = cur_pk | trip_act;
      bf_timing_pkg::CRIT_DO: run = trip_act;
    endcase
    pickup = cur_pk | (crit != bf_timing_pkg::CRIT_CURRENT && trip_act);
  end
  always_comb begin
    blk_next = blk_reg;
    tmr_next = tmr_reg;
    start_next = start_reg;
    rt_next = rt_reg;
    bf_next = bf_reg;
    bk_next = bk_reg;
    if (tick) begin
      // block is latched here and held for the whole cycle
      blk_next = blk_sync_reg[1] | (beh == bf_timing_pkg::BEH_BLOCKED) |
        (beh == bf_timing_pkg::BEH_TEST_BLOCKED);
      if (beh == bf_timing_pkg::BEH_OFF) begin
        tmr_next = 32'h0;
        {start_next, rt_next, bf_next, bk_next} = 4'h0;
      end else if (blk_next) begin
        // blocked: drop everything as on loss of pick-up
        tmr_next = 32'h0;
        {start_next, rt_next, bf_next} = 3'h0;
        bk_next = pickup;
      end else if (run) begin
        // one shared timer drives both delays
        tmr_next = (tmr_reg == 32'hFFFF_FFFF) ? tmr_reg : tmr_reg + 32'h1;
        start_next = 1'b1;
        bk_next = 1'b0;
        rt_next = retr_en && (tmr_next >= retr_dly_reg);
        bf_next = tmr_next >= bf_dly_reg;
      end else begin
        tmr_next = 32'h0;
        start_next = pickup;
        {rt_next, bf_next, bk_next} = 3'h0;
      end
    end
    // disabling retrip drops it at once, not at the next cycle tick
    if (!retr_en) rt_next = 1'b0;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pk_reg <= 4'h0;
      blk_reg <= 1'b0;
      tmr_reg <= 32'h0;
      start_reg <= 1'b0;
      rt_reg <= 1'b0;
      bf_reg <= 1'b0;
      bk_reg <= 1'b0;
    end else begin
      pk_reg <= pk_next;
      blk_reg <= blk_next;
      tmr_reg <= tmr_next;
      start_reg <= start_next;
      rt_reg <= rt_next;
      bf_reg <= bf_next;
      bk_reg <= bk_next;
    end
  end
  // ------------------------------------------------------------
  // reported state
  // ------------------------------------------------------------
  bf_timing_pkg::condition_t cond;
  always_comb begin
    if (bf_reg) cond = bf_timing_pkg::COND_BF_ON;
    else if (rt_reg) cond = bf_timing_pkg::COND_RETRIP;
    else if (start_reg) cond = bf_timing_pkg::COND_START;
    else if (bk_reg) cond = bf_timing_pkg::COND_BLOCKED;
    else cond = bf_timing_pkg::COND_NORMAL;
  end
  assign start_out = start_reg;
  assign retrip_out = rt_reg;
  assign breaker_failure_trip = bf_reg;
  assign blocked_out = bk_reg;
  assign function_condition = cond;
  assign logical_node_behaviour = beh;
  // ------------------------------------------------------------
  // axi4-lite slave, one transaction of each kind at a time
  // ------------------------------------------------------------
  logic aw_ok, w_ok, b_reg, b_next, r_reg, r_next;
  logic [7:0] awa_reg, awa_next;
  logic [31:0] wd_reg, wd_next, rd_reg, rd_next;
  logic [3:0] ws_reg, ws_next;
  logic aw_have_reg, aw_have_next, w_have_reg, w_have_next;
  logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic [31:0] ctrl_next, ph_next, res_next, rdl_next, bdl_next, cyc_next;
  function automatic logic [31:0] merge(input logic [31:0] old,
      input logic [31:0] d, input logic [3:0] s);
    for (int i = 0; i < 4; i++) if (s[i]) old[i*8 +: 8] = d[i*8 +: 8];
    return old;
  endfunction : merge
  assign s_awready = !aw_have_reg && !b_reg;
  assign s_wready = !w_have_reg && !b_reg;
  assign s_arready = !r_reg;
  assign aw_ok = s_awvalid && s_awready;
  assign w_ok = s_wvalid && s_wready;
  always_comb begin
    awa_next = aw_ok ? s_awaddr : awa_reg;
    wd_next = w_ok ? s_wdata : wd_reg;
    ws_next = w_ok ? s_wstrb : ws_reg;
    aw_have_next = aw_have_reg | aw_ok;
    w_have_next = w_have_reg | w_ok;
    b_next = b_reg && !s_bready;
    bresp_next = bresp_reg;
    {ctrl_next, ph_next, res_next} = {ctrl_reg, ph_thr_reg, res_thr_reg};
    {rdl_next, bdl_next} = {retr_dly_reg, bf_dly_reg};
    cyc_next = tick ? cycle_cnt_reg + 32'h1 : cycle_cnt_reg;
    if (aw_have_next && w_have_next && !b_reg) begin
      aw_have_next = 1'b0;
      w_have_next = 1'b0;
      b_next = 1'b1;
      bresp_next = bf_timing_pkg::RESP_OKAY;
      unique case (awa_next)
        bf_timing_pkg::CTRL_OFF: ctrl_next = merge(ctrl_reg, wd_next, ws_next);
        bf_timing_pkg::PH_THR_OFF:
          ph_next = merge(ph_thr_reg, wd_next, ws_next);
        bf_timing_pkg::RES_THR_OFF:
          res_next = merge(res_thr_reg, wd_next, ws_next);
        bf_timing_pkg::RETR_DLY_OFF:
          rdl_next = merge(retr_dly_reg, wd_next, ws_next);
        bf_timing_pkg::BF_DLY_OFF:
          bdl_next = merge(bf_dly_reg, wd_next, ws_next);
        bf_timing_pkg::STATUS_OFF, bf_timing_pkg::CYCLE_OFF: ;
        default: bresp_next = bf_timing_pkg::RESP_SLVERR;
      endcase
    end
    r_next = r_reg ? !s_rready : s_arvalid;
    rd_next = rd_reg;
    rresp_next = rresp_reg;
    if (s_arvalid && s_arready) begin
      rresp_next = bf_timing_pkg::RESP_OKAY;
      unique case (s_araddr)
        bf_timing_pkg::CTRL_OFF: rd_next = ctrl_reg;
        bf_timing_pkg::PH_THR_OFF: rd_next = ph_thr_reg;
        bf_timing_pkg::RES_THR_OFF: rd_next = res_thr_reg;
        bf_timing_pkg::RETR_DLY_OFF: rd_next = retr_dly_reg;
        bf_timing_pkg::BF_DLY_OFF: rd_next = bf_dly_reg;
        bf_timing_pkg::STATUS_OFF:
          rd_next = {20'h0, bk_reg, bf_reg, rt_reg, start_reg, 1'b0, beh,
            1'b0, cond};
        bf_timing_pkg::CYCLE_OFF: rd_next = cycle_cnt_reg;
        default: begin
          rd_next = 32'h0;
          rresp_next = bf_timing_pkg::RESP_SLVERR;
        end
      endcase
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= bf_timing_pkg::CTRL_RESET;
      ph_thr_reg <= bf_timing_pkg::PH_THR_RESET;
      res_thr_reg <= bf_timing_pkg::RES_THR_RESET;
      retr_dly_reg <= bf_timing_pkg::RETR_DEF_STEPS;
      bf_dly_reg <= bf_timing_pkg::BF_DEF_STEPS;
      cycle_cnt_reg <= 32'h0;
      awa_reg <= 8'h0;
      wd_reg <= 32'h0;
      ws_reg <= 4'h0;
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      b_reg <= 1'b0;
      bresp_reg <= 2'h0;
      r_reg <= 1'b0;
      rd_reg <= 32'h0;
      rresp_reg <= 2'h0;
    end else begin
      ctrl_reg <= ctrl_next;
      ph_thr_reg <= ph_next;
      res_thr_reg <= res_next;
      retr_dly_reg <= rdl_next;
      bf_dly_reg <= bdl_next;
      cycle_cnt_reg <= cyc_next;
      awa_reg <= awa_next;
      wd_reg <= wd_next;
      ws_reg <= ws_next;
      aw_have_reg <= aw_have_next;
      w_have_reg <= w_have_next;
      b_reg <= b_next;
      bresp_reg <= bresp_next;
      r_reg <= r_next;
      rd_reg <= rd_next;
      rresp_reg <= rresp_next;
    end
  end
  assign s_bvalid = b_reg;
  assign s_bresp = bresp_reg;
  assign s_rvalid = r_reg;
  assign s_rdata = rd_reg;
  assign s_rresp = rresp_reg;
  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_retrip_disabled: assert property (!retr_en |=> !rt_reg)
    else $error("retrip asserted while disabled");
  a_bf_needs_delay: assert property (
    $rose(bf_reg) |-> tmr_reg >= bf_dly_reg)
    else $error("failure output before its delay");
  a_rt_needs_delay: assert property (
    $rose(rt_reg) |-> tmr_reg >= retr_dly_reg)
    else $error("retrip before its delay");
  a_block_drops_start: assert property (
    tick && blk_next |=> !start_reg && tmr_reg == 32'h0)
    else $error("start survived blocking");
  a_block_steady: assert property (!tick |=> $stable(blk_reg))
    else $error("block changed mid cycle");
  a_timer_on_tick: assert property (!tick |=> $stable(tmr_reg))
    else $error("timer moved off tick");
  a_and_halts: assert property (
    tick && crit == bf_timing_pkg::CRIT_AND_DO && !trip_act |=> tmr_reg == 0)
    else $error("and criterion ran without trip");
  a_outputs_imply_start: assert property (
    (rt_reg || bf_reg) |-> start_reg)
    else $error("timer outputs without start");
  a_blocked_no_timer: assert property (
    bk_reg |-> tmr_reg == 32'h0 && !start_reg)
    else $error("blocked with timer running");
endmodule : breaker_failure_timing_logic

// ### src/bf_timing_pkg.sv
// constants and types of the breaker failure timing block
package bf_timing_pkg;
  // ------------------------------------------------------------
  // register map (byte offsets)
  // ------------------------------------------------------------
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] PH_THR_OFF = 8'h04;
  localparam logic [7:0] RES_THR_OFF = 8'h08;
  localparam logic [7:0] RETR_DLY_OFF = 8'h0C;
  localparam logic [7:0] BF_DLY_OFF = 8'h10;
  localparam logic [7:0] STATUS_OFF = 8'h14;
  localparam logic [7:0] CYCLE_OFF = 8'h18;
  // ------------------------------------------------------------
  // control fields
  // ------------------------------------------------------------
  localparam int CTRL_CRIT_LSB = 0;
  localparam int CTRL_RETR_EN = 2;
  localparam int CTRL_MODE_LSB = 4;
  localparam int CTRL_RES_EN = 7;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0004;
  // status fields
  localparam int ST_COND_LSB = 0;
  localparam int ST_BEH_LSB = 4;
  localparam int ST_START = 8;
  localparam int ST_RETRIP = 9;
  localparam int ST_BF = 10;
  localparam int ST_BLOCKED = 11;
  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CLK_MHZ = 100;
  localparam int CYCLE_US = 5000;
  localparam int CYCLE_CLKS = CYCLE_US * CLK_MHZ;
  localparam int BLOCK_LEAD_MS = 5;
  localparam int STEP_MS = 5;
  localparam int RETR_DEF_MS = 100;
  localparam int BF_DEF_MS = 200;
  localparam logic [31:0] RETR_DEF_STEPS = 32'(RETR_DEF_MS / STEP_MS);
  localparam logic [31:0] BF_DEF_STEPS = 32'(BF_DEF_MS / STEP_MS);
  localparam int PCT_RELEASE = 97;
  localparam logic [31:0] PH_THR_RESET = 32'h0000_00C8;
  localparam logic [31:0] RES_THR_RESET = 32'h0000_04B0;
  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    CRIT_CURRENT, CRIT_AND_DO, CRIT_OR_DO, CRIT_DO
  } criterion_t;
  typedef enum logic [2:0] {
    BEH_ON, BEH_BLOCKED, BEH_TEST, BEH_TEST_BLOCKED, BEH_OFF
  } behaviour_t;
  typedef enum logic [2:0] {
    COND_NORMAL, COND_START, COND_RETRIP, COND_BF_ON, COND_BLOCKED
  } condition_t;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : bf_timing_pkg

// ### tb/protection_side_model.sv
// behavioural primary protection stage, breaker and its redundant coil
`timescale 1ns/1ps
module protection_side_model (
  // clock
  input wire logic aclk,
  // fault scene set by the bench
  input wire logic [31:0] fault_level,
  input wire logic [2:0] fault_phases,
  input wire logic [31:0] res_level,
  input wire logic trip_req,
  input wire logic coil_works,
  // second coil drive from the block
  input wire logic retrip_out,
  // measured magnitudes and primary trip contact
  output logic [31:0] phase_mag [3],
  output logic [31:0] residual_mag,
  output logic primary_trip_pin,
  output logic breaker_open
);
  initial begin
    phase_mag = '{default: 32'h0};
    residual_mag = 32'h0;
    primary_trip_pin = 1'h0;
    breaker_open = 1'h0;
  end
  // a stuck breaker is the default so the failure path is reachable;
  // the coil only opens it when the bench says the coil works
  always @(posedge aclk) begin
    if (coil_works && retrip_out)
      breaker_open <= 1'h1;
    else if (fault_phases == 3'h0 && res_level == 32'h0)
      breaker_open <= 1'h0;
    for (int i = 0; i < 3; i++)
      phase_mag[i] <= (fault_phases[i] && !breaker_open) ? fault_level : 32'h0;
    residual_mag <= breaker_open ? 32'h0 : res_level;
    primary_trip_pin <= trip_req;
  end
endmodule : protection_side_model

// ### tb/breaker_failure_timing_logic_test.sv
// self-checking bench for the breaker failure timing block
`timescale 1ns/1ps
`define CHK(nm, exp, got) \
  begin \
    tests_run++; \
    if ((got) !== (exp)) begin \
      failures++; \
      $display("CHECK FAILED %s exp %0h got %0h", nm, exp, got); \
    end \
  end
module breaker_failure_timing_logic_test;
  // short program cycle keeps the run small; delays below count in cycles
  localparam int CYC = 20;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [31:0] phase_mag [3];
  logic [31:0] residual_mag;
  logic block_pin = 1'h0;
  logic primary_trip_pin, breaker_open;
  logic start_out, retrip_out, breaker_failure_trip, blocked_out;
  logic [2:0] function_condition, logical_node_behaviour;
  logic [7:0] s_awaddr = 8'h00;
  logic [7:0] s_araddr = 8'h00;
  logic [31:0] s_wdata = 32'h0;
  logic [3:0] s_wstrb = 4'h0;
  logic s_awvalid = 1'h0, s_wvalid = 1'h0, s_bready = 1'h0;
  logic s_arvalid = 1'h0, s_rready = 1'h0;
  logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
  logic [1:0] s_bresp, s_rresp, rsp;
  logic [31:0] s_rdata, rd;
  logic [31:0] lvl = 32'h0;
  logic [31:0] rlvl = 32'h0;
  logic [2:0] phs = 3'h0;
  logic trip_req = 1'h0, coil_ok = 1'h0;
  int failures = 0;
  int tests_run = 0;

  always #5 aclk = ~aclk;

  breaker_failure_timing_logic #(.CYCLE_CLKS(CYC)) i_dut (
    .aclk(aclk), .aresetn(aresetn), .phase_mag(phase_mag),
    .residual_mag(residual_mag), .block_pin(block_pin),
    .primary_trip_pin(primary_trip_pin), .start_out(start_out),
    .retrip_out(retrip_out), .breaker_failure_trip(breaker_failure_trip),
    .blocked_out(blocked_out), .function_condition(function_condition),
    .logical_node_behaviour(logical_node_behaviour),
    .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready),
    .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid),
    .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid),
    .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
    .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp),
    .s_rvalid(s_rvalid), .s_rready(s_rready));

  protection_side_model i_side (
    .aclk(aclk), .fault_level(lvl), .fault_phases(phs), .res_level(rlvl),
    .trip_req(trip_req), .coil_works(coil_ok), .retrip_out(retrip_out),
    .phase_mag(phase_mag), .residual_mag(residual_mag),
    .primary_trip_pin(primary_trip_pin), .breaker_open(breaker_open));

  // ------------------------------------------------------------
  // bus and check tasks
  // ------------------------------------------------------------
  task automatic ticks(input int n);
    repeat (n * CYC) @(posedge aclk);
  endtask : ticks

  // ready and valid are stable between edges, so look at the falling edge
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w;
    aw = 1'h0;
    w = 1'h0;
    @(posedge aclk);
    s_awaddr <= a;
    s_awvalid <= 1'h1;
    s_wdata <= d;
    s_wstrb <= 4'hF;
    s_wvalid <= 1'h1;
    s_bready <= 1'h1;
    while (!(aw && w)) begin
      @(negedge aclk);
      aw = aw | s_awready;
      w = w | s_wready;
      @(posedge aclk);
      if (aw) s_awvalid <= 1'h0;
      if (w) s_wvalid <= 1'h0;
    end
    do @(negedge aclk); while (!s_bvalid);
    rsp = s_bresp;
    @(posedge aclk);
    s_bready <= 1'h0;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a);
    @(posedge aclk);
    s_araddr <= a;
    s_arvalid <= 1'h1;
    s_rready <= 1'h1;
    do @(negedge aclk); while (!s_arready);
    @(posedge aclk);
    s_arvalid <= 1'h0;
    do @(negedge aclk); while (!s_rvalid);
    rd = s_rdata;
    rsp = s_rresp;
    @(posedge aclk);
    s_rready <= 1'h0;
  endtask : axi_rd

  task automatic cfg(input logic [1:0] crit, input logic ren,
                     input logic [2:0] mode, input logic res);
    axi_wr(bf_timing_pkg::CTRL_OFF, {24'h0, res, mode, 1'h0, ren, crit});
  endtask : cfg

  // outputs packed as start, retrip, failure trip, blocked
  task automatic outs(input string nm, input logic [3:0] e,
                      input logic [2:0] c);
    @(negedge aclk);
    `CHK(nm, e, {start_out, retrip_out, breaker_failure_trip, blocked_out})
    `CHK(nm, c, function_condition)
    @(posedge aclk);
  endtask : outs

  task automatic pair(input string nm, input logic [1:0] e);
    @(negedge aclk);
    `CHK(nm, e, {retrip_out, breaker_failure_trip})
    @(posedge aclk);
  endtask : pair

  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : summarize

  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    outs("reset", 4'h0, bf_timing_pkg::COND_NORMAL);
    `CHK("behaviour", 3'h0, logical_node_behaviour)
    axi_rd(bf_timing_pkg::CTRL_OFF);
    `CHK("ctrl", bf_timing_pkg::CTRL_RESET, rd)
    axi_rd(bf_timing_pkg::RETR_DLY_OFF);
    `CHK("retrip dly", bf_timing_pkg::RETR_DEF_STEPS, rd)
    axi_rd(bf_timing_pkg::BF_DLY_OFF);
    `CHK("bf dly", bf_timing_pkg::BF_DEF_STEPS, rd)
    axi_rd(bf_timing_pkg::PH_THR_OFF);
    `CHK("phase thr", bf_timing_pkg::PH_THR_RESET, rd)
    axi_rd(8'h1C);
    `CHK("spare", {bf_timing_pkg::RESP_SLVERR, 32'h0}, {rsp, rd})
    // retrip well ahead of the failure delay keeps the grading sane
    axi_wr(bf_timing_pkg::RETR_DLY_OFF, 32'h3);
    `CHK("wr resp", bf_timing_pkg::RESP_OKAY, rsp)
    axi_wr(bf_timing_pkg::BF_DLY_OFF, 32'h8);
    $display("test reset_and_map done");

    cfg(2'h0, 1'h1, 3'h0, 1'h0);
    trip_req <= 1'h1;
    ticks(6);
    outs("trip ignored", 4'h0, bf_timing_pkg::COND_NORMAL);
    trip_req <= 1'h0;
    lvl <= 32'h12C;
    phs <= 3'h2;
    ticks(2);
    outs("start", 4'h8, bf_timing_pkg::COND_START);
    ticks(4);
    outs("retrip", 4'hC, bf_timing_pkg::COND_RETRIP);
    ticks(5);
    outs("bf", 4'hE, bf_timing_pkg::COND_BF_ON);
    axi_rd(bf_timing_pkg::STATUS_OFF);
    `CHK("status", 32'h0000_0703, rd & 32'h0000_0F77)
    lvl <= 32'hC3;
    ticks(2);
    outs("hysteresis", 4'hE, bf_timing_pkg::COND_BF_ON);
    lvl <= 32'hBE;
    ticks(2);
    outs("release", 4'h0, bf_timing_pkg::COND_NORMAL);
    $display("test current_only done");

    cfg(2'h1, 1'h1, 3'h0, 1'h0);
    lvl <= 32'h12C;
    phs <= 3'h7;
    ticks(7);
    pair("and halted", 2'h0);
    trip_req <= 1'h1;
    ticks(2);
    pair("and early", 2'h0);
    ticks(3);
    pair("and retrip", 2'h2);
    ticks(6);
    pair("and bf", 2'h3);
    trip_req <= 1'h0;
    ticks(2);
    pair("and trip drop", 2'h0);
    trip_req <= 1'h1;
    ticks(6);
    pair("and again", 2'h2);
    phs <= 3'h0;
    ticks(2);
    pair("and cur drop", 2'h0);
    $display("test current_and_trip done");

    cfg(2'h2, 1'h1, 3'h0, 1'h0);
    ticks(5);
    pair("or trip", 2'h2);
    phs <= 3'h7;
    trip_req <= 1'h0;
    ticks(2);
    pair("or cur", 2'h2);
    phs <= 3'h0;
    ticks(2);
    pair("or clear", 2'h0);
    $display("test current_or_trip done");

    cfg(2'h0, 1'h0, 3'h0, 1'h1);
    rlvl <= 32'h514;
    ticks(11);
    outs("no retrip", 4'hA, bf_timing_pkg::COND_BF_ON);
    rlvl <= 32'h0;
    ticks(2);
    outs("res release", 4'h0, bf_timing_pkg::COND_NORMAL);
    $display("test retrip_off done");

    cfg(2'h0, 1'h1, 3'h0, 1'h0);
    coil_ok <= 1'h1;
    phs <= 3'h7;
    ticks(14);
    outs("coil cleared", 4'h0, bf_timing_pkg::COND_NORMAL);
    `CHK("breaker open", 1'h1, breaker_open)
    phs <= 3'h0;
    coil_ok <= 1'h0;
    $display("test coil_clears done");

    block_pin <= 1'h1;
    ticks(1);
    phs <= 3'h7;
    ticks(3);
    outs("blocked", 4'h1, bf_timing_pkg::COND_BLOCKED);
    ticks(3);
    outs("no timers", 4'h1, bf_timing_pkg::COND_BLOCKED);
    block_pin <= 1'h0;
    ticks(1);
    outs("unblocked", 4'h8, bf_timing_pkg::COND_START);
    // block lands over a program cycle before the retrip delay runs out
    block_pin <= 1'h1;
    ticks(2);
    outs("start drop", 4'h1, bf_timing_pkg::COND_BLOCKED);
    ticks(4);
    outs("held off", 4'h1, bf_timing_pkg::COND_BLOCKED);
    block_pin <= 1'h0;
    phs <= 3'h0;
    ticks(2);
    outs("idle", 4'h0, bf_timing_pkg::COND_NORMAL);
    $display("test blocking done");

    for (int m = 0; m < 5; m++) begin
      cfg(2'h0, 1'h1, 3'(m), 1'h0);
      axi_rd(bf_timing_pkg::STATUS_OFF);
      `CHK("beh port", 3'(m), logical_node_behaviour)
      `CHK("beh status", 3'(m), rd[6:4])
    end
    cfg(2'h0, 1'h1, 3'h0, 1'h0);
    $display("test behaviour done");
    summarize();
  end

  initial begin
    repeat (20000) @(posedge aclk);
    failures++;
    $display("watchdog expired");
    summarize();
  end
endmodule : breaker_failure_timing_logic_test
